// ### rtl/supply_monitor_regs.sv
// Register bank of the supply droop monitor and its warning monitor
//
// Contract
// - Sample-rate bit: 0 means 1 kHz, 1 means 125 Hz; reset from fuse.
// - Sample-rate bit is read-only and outside the unlock scheme.
// - Awake mode bits 3:2: disabled, continuous, sampled, continuous with hold.
// - Awake mode is read-only, reset from the matching fuse field.
// - Low-power mode bits 1:0 writable; 0x3 is reserved.
// - Control B bits 2:0 show the read-only fuse trip level.
// - Warning margin bits 1:0 at 0x08 select 5, 15 or 25 percent.
// - Direction bits 2:1 select below, above or either crossing.
// - Interrupt control bit 0 enables the warning interrupt.
// - Warning flag sets on a matching crossing, only while monitor enabled.
// - Live status bit reads 1 when supply is below the warning threshold.
// - Interrupt control, flag and status registers reset to zero.
// - Interrupt request stands while enable and flag are both set.
// - Warning monitor follows the droop monitor mode, off when disabled; here it is also off while interrupt enable bit 0 is clear.
// - Low-power mode in standby, awake mode after waking.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "supply_monitor_defs.svh"
module supply_monitor_regs (
	input  wire logic                              ref_clk,
	input  wire logic                              sys_rst,
	input  wire supply_monitor_pkg::bus_req_type   bus_req,
	input  wire supply_monitor_pkg::fuse_cfg_type  monitor_fuse_cfg,
	input  wire logic                              unlock_key_write,
	input  wire logic [7:0]                        unlock_key_data,
	input  wire logic                              instr_step,
	input  wire logic                              deep_sleep,
	input  wire logic                              comparator_below,
	output logic [7:0]                             rdata,
	output logic                                   warn_irq,
	output logic                                   event_irq,
	output supply_monitor_pkg::monitor_mode_type   active_mode,
	output logic                                   active_sample_rate,
	output logic [2:0]                             trip_level,
	output logic [1:0]                             warn_margin_sel,
	output logic                                   warn_monitor_on
);
	import supply_monitor_pkg::*;

	fuse_cfg_type     fuse_latched;
	monitor_mode_type low_power_mode;
	logic [1:0]       margin;
	direction_type    warn_direction_sel;
	logic             warn_irq_enable;
	logic             warn_irq_flag;
	logic             warn_below_state;
	logic             below_sync;
	logic             below_prev;
	logic             fuse_loaded;
	logic [2:0]       unlock_count;
	logic [`EVENT_BITS-1:0] event_status;
	logic [`EVENT_BITS-1:0] event_mask;
	logic             monitor_enabled;
	logic             crossing_hit;
	logic             flag_write;
	logic             flag_clear;
	logic             lp_write;
	logic             unlocked;
	logic             event_read;
	logic [`EVENT_BITS-1:0] next_event_status;
	logic [`EVENT_BITS-1:0] event_hit;
	logic [7:0]       next_rdata;

	// The comparator output is analog timing, so resync before use
	pin_sync below_pin (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.async_in (comparator_below),
		.sync_out (below_sync)
	);

	// Fuses captured on the first clock after reset release, never async
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			fuse_loaded  <= 1'b0;
			fuse_latched <= '0;
		end else if (!fuse_loaded) begin
			fuse_loaded  <= 1'b1;
			fuse_latched <= monitor_fuse_cfg;
		end
	end

	// Unlock window counts instruction steps after the key
	assign unlocked = (unlock_count != 3'h0);
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			unlock_count <= 3'h0;
		end else if (unlock_key_write &&
				unlock_key_data == `KEY_VALUE) begin
			unlock_count <= `UNLOCK_WINDOW;
		end else if (instr_step && unlocked) begin
			unlock_count <= unlock_count - 3'h1;
		end
	end

	assign lp_write = bus_req.write && bus_req.addr == `OFS_CONTROL_A;

	// Only the low-power field is writable, and only inside the window
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			low_power_mode <= mode_disabled;
		end else if (!fuse_loaded) begin
			low_power_mode <= monitor_fuse_cfg.low_power_mode;
		end else if (lp_write && unlocked &&
				bus_req.wdata[1:0] != `MODE_RESERVED) begin
			low_power_mode <= monitor_mode_type'(bus_req.wdata[1:0]);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			margin <= 2'h0;
		end else if (bus_req.write &&
				bus_req.addr == `OFS_LEVEL_CONTROL) begin
			margin <= bus_req.wdata[1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			warn_direction_sel <= dir_below;
			warn_irq_enable    <= 1'b0;
		end else if (bus_req.write &&
				bus_req.addr == `OFS_IRQ_CONTROL) begin
			warn_direction_sel <= direction_type'(bus_req.wdata[2:1]);
			warn_irq_enable    <= bus_req.wdata[0];
		end
	end

	// Mode in force: low-power setting while asleep, awake otherwise
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			active_mode        <= mode_disabled;
			active_sample_rate <= 1'b0;
			trip_level         <= 3'h0;
			warn_margin_sel    <= 2'h0;
			warn_monitor_on    <= 1'b0;
		end else begin
			active_mode        <= deep_sleep ? low_power_mode
				: fuse_latched.awake_mode;
			active_sample_rate <= fuse_latched.sample_rate_sel;
			trip_level         <= fuse_latched.trip_level;
			warn_margin_sel    <= margin;
			warn_monitor_on    <= monitor_enabled && warn_irq_enable;
		end
	end

	assign monitor_enabled = fuse_loaded && active_mode != mode_disabled;

	// Crossing detection on the synchronised comparator level
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			below_prev       <= 1'b0;
			warn_below_state <= 1'b0;
		end else if (monitor_enabled) begin
			below_prev       <= below_sync;
			warn_below_state <= below_sync;
		end
	end

	always_comb begin
		case (warn_direction_sel)
			dir_below: crossing_hit = below_sync && !below_prev;
			dir_above: crossing_hit = !below_sync && below_prev;
			dir_cross: crossing_hit = below_sync != below_prev;
			default:   crossing_hit = 1'b0;
		endcase
	end

	assign flag_write = bus_req.write && bus_req.addr == `OFS_IRQ_FLAGS;
	assign flag_clear = flag_write && bus_req.wdata[0];

	// A crossing in the clearing cycle keeps the flag set
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			warn_irq_flag <= 1'b0;
		end else if (monitor_enabled && crossing_hit) begin
			warn_irq_flag <= 1'b1;
		end else if (flag_clear) begin
			warn_irq_flag <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			warn_irq <= 1'b0;
		end else begin
			warn_irq <= warn_irq_enable && (warn_irq_flag ||
				(monitor_enabled && crossing_hit)) &&
				!(flag_clear && !(monitor_enabled && crossing_hit));
		end
	end

	// Event status: sticky, cleared by reading, masked onto event_irq
	assign event_read = bus_req.read && bus_req.addr == `OFS_EVENT_STATUS;
	always_comb begin
		event_hit = '0;
		event_hit[`EVT_FLAG_SET]  = monitor_enabled && crossing_hit;
		event_hit[`EVT_BAD_WRITE] = lp_write && !unlocked;
		next_event_status = (event_read ? '0 : event_status) | event_hit;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			event_status <= '0;
		end else begin
			event_status <= next_event_status;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			event_mask <= '0;
		end else if (bus_req.write &&
				bus_req.addr == `OFS_EVENT_MASK) begin
			event_mask <= bus_req.wdata[`EVENT_BITS-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			event_irq <= 1'b0;
		end else begin
			event_irq <= |(next_event_status & event_mask);
		end
	end

	// Read mux; reserved and unmapped offsets read zero
	always_comb begin
		next_rdata = `RESET_BYTE;
		case (bus_req.addr)
			`OFS_CONTROL_A: next_rdata = {3'h0,
				fuse_latched.sample_rate_sel,
				fuse_latched.awake_mode, low_power_mode};
			`OFS_CONTROL_B: next_rdata = {5'h0,
				fuse_latched.trip_level};
			`OFS_LEVEL_CONTROL: next_rdata = {6'h0, margin};
			`OFS_IRQ_CONTROL: next_rdata = {5'h0, warn_direction_sel,
				warn_irq_enable};
			`OFS_IRQ_FLAGS: next_rdata = {7'h0, warn_irq_flag};
			`OFS_LIVE_STATUS: next_rdata = {7'h0, warn_below_state};
			`OFS_EVENT_STATUS: next_rdata = {6'h0, event_status};
			`OFS_EVENT_MASK: next_rdata = {6'h0, event_mask};
			default: next_rdata = `RESET_BYTE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdata <= `RESET_BYTE;
		end else if (bus_req.read) begin
			rdata <= next_rdata;
		end else begin
			rdata <= `RESET_BYTE;
		end
	end
endmodule : supply_monitor_regs

// ### rtl/supply_monitor_defs.svh
// Register offsets, field positions and reset values of the supply monitor
`ifndef SUPPLY_MONITOR_DEFS_SVH
`define SUPPLY_MONITOR_DEFS_SVH
`define OFS_CONTROL_A        4'h0
`define OFS_CONTROL_B        4'h1
`define OFS_LEVEL_CONTROL    4'h8
`define OFS_IRQ_CONTROL      4'h9
`define OFS_IRQ_FLAGS        4'ha
`define OFS_LIVE_STATUS      4'hb
`define OFS_EVENT_STATUS     4'hc
`define OFS_EVENT_MASK       4'hd
`define RESET_BYTE           8'h00
`define KEY_VALUE            8'hd8
`define UNLOCK_WINDOW        3'h4
`define MODE_RESERVED        2'h3
`define EVENT_BITS           2
`define EVT_FLAG_SET         0
`define EVT_BAD_WRITE        1
`endif

// ### rtl/supply_monitor_pkg.sv
// Types shared by the supply monitor register bank
package supply_monitor_pkg;
	typedef enum logic [1:0] {
		mode_disabled,
		mode_continuous,
		mode_sampled,
		mode_wake_hold
	} monitor_mode_type;
	typedef enum logic [1:0] {
		dir_below,
		dir_above,
		dir_cross,
		dir_reserved
	} direction_type;
	typedef struct packed {
		logic             sample_rate_sel;
		monitor_mode_type awake_mode;
		monitor_mode_type low_power_mode;
		logic [2:0]       trip_level;
	} fuse_cfg_type;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       write;
		logic       read;
	} bus_req_type;
endpackage : supply_monitor_pkg

// ### rtl/pin_sync.sv
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module pin_sync (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic async_in,
	output logic      sync_out
);
	logic stage_one;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stage_one <= 1'b0;
			sync_out  <= 1'b0;
		end else begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end
endmodule : pin_sync

// ### test/supply_monitor_regs_checker.sv
// Port-level assertions for the supply monitor register bank
`timescale 1ns/1ps
module supply_monitor_regs_checker (
	input wire logic                            ref_clk,
	input wire logic                            sys_rst,
	input wire supply_monitor_pkg::bus_req_type bus_req,
	input wire logic                            deep_sleep,
	input wire logic [7:0]                      rdata,
	input wire logic                            warn_irq,
	input wire supply_monitor_pkg::monitor_mode_type active_mode,
	input wire logic [2:0]                      trip_level,
	input wire logic [1:0]                      warn_margin_sel,
	input wire logic                            warn_monitor_on
);
	import supply_monitor_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_rd(logic [3:0] a);
		bus_req.read && bus_req.addr == a;
	endsequence
	// A write just before the read may still be settling into the mode
	sequence s_quiet_rd(logic [3:0] a);
		!bus_req.write ##1 s_rd(a);
	endsequence
	property p_reserved;
		bus_req.read && bus_req.addr inside {[4'h2:4'h7]} |=> rdata == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved nonzero");
	property p_ctrl_a; s_rd(4'h0) |=> rdata[7:5] == 3'h0; endproperty
	a_ctrl_a: assert property (p_ctrl_a) else $error("control a upper");
	property p_ctrl_b; s_rd(4'h1) |=> rdata == {5'h00, trip_level}; endproperty
	a_ctrl_b: assert property (p_ctrl_b) else $error("trip level read");
	property p_flags; s_rd(4'ha) |=> rdata[7:1] == 7'h00; endproperty
	a_flags: assert property (p_flags) else $error("flag upper bits");
	property p_status; s_rd(4'hb) |=> rdata[7:1] == 7'h00; endproperty
	a_status: assert property (p_status) else $error("status upper bits");
	property p_margin;
		bus_req.write && bus_req.addr == 4'h8 && bus_req.wdata[1:0] != 2'h3
		|=> ##1 warn_margin_sel == $past(bus_req.wdata[1:0], 2);
	endproperty
	a_margin: assert property (p_margin) else $error("margin not taken");
	property p_irq_off;
		bus_req.write && bus_req.addr == 4'h9 && !bus_req.wdata[0]
		|=> ##1 !warn_irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq not off");
	property p_mon_off;
		(active_mode == mode_disabled) [*3] |-> !$past(warn_monitor_on);
	endproperty
	a_mon_off: assert property (p_mon_off) else $error("monitor on");
	property p_sleep;
		deep_sleep [*3] ##0 s_quiet_rd(4'h0) ##0 deep_sleep
		|=> active_mode == rdata[1:0];
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep mode");
	property p_awake;
		!deep_sleep [*3] ##0 s_quiet_rd(4'h0) ##0 !deep_sleep
		|=> active_mode == rdata[3:2];
	endproperty
	a_awake: assert property (p_awake) else $error("awake mode");
endmodule : supply_monitor_regs_checker

bind supply_monitor_regs supply_monitor_regs_checker chk (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req),
	.deep_sleep(deep_sleep), .rdata(rdata), .warn_irq(warn_irq),
	.active_mode(active_mode), .trip_level(trip_level),
	.warn_margin_sel(warn_margin_sel), .warn_monitor_on(warn_monitor_on)
);

// ### test/supply_monitor_regs_bench.sv
// Self-checking bench for the supply monitor register bank
`timescale 1ns/1ps
module supply_monitor_regs_bench;
	import supply_monitor_pkg::*;
	logic             ref_clk = 1'b0;
	logic             sys_rst = 1'b1;
	bus_req_type      bus_req = '0;
	fuse_cfg_type     fuse = '0;
	logic             key_wr = 1'b0;
	logic [7:0]       key_data = 8'h00;
	logic             step = 1'b0;
	logic             deep_sleep = 1'b0;
	logic             below = 1'b0;
	logic [7:0]       rdata;
	logic             warn_irq, event_irq, rate, mon_on, e0;
	monitor_mode_type active_mode;
	logic [2:0]       trip;
	logic [1:0]       margin;
	int               n_errors = 0;
	int               num_checks = 0;
	int               dirs[5] = '{1, 1, 0, 0, 2};
	logic [4:0]       lvls = 5'b01010;
	logic [4:0]       exps = 5'b11001;

	supply_monitor_regs uut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req),
		.monitor_fuse_cfg(fuse), .unlock_key_write(key_wr),
		.unlock_key_data(key_data), .instr_step(step),
		.deep_sleep(deep_sleep), .comparator_below(below),
		.rdata(rdata), .warn_irq(warn_irq), .event_irq(event_irq),
		.active_mode(active_mode), .active_sample_rate(rate),
		.trip_level(trip), .warn_margin_sel(margin),
		.warn_monitor_on(mon_on)
	);

	always #20 ref_clk = ~ref_clk;

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		bus_req <= '0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		bus_req <= '0;
		#1 check(rdata, exp);
	endtask : rd_check
	task automatic unlock_wr(input logic [7:0] d, input int steps);
		@(posedge ref_clk);
		key_wr <= 1'b1;
		key_data <= 8'hd8;
		@(posedge ref_clk);
		key_wr <= 1'b0;
		repeat (steps) begin
			step <= 1'b1;
			@(posedge ref_clk);
			step <= 1'b0;
			@(posedge ref_clk);
		end
		wr(4'h0, d);
	endtask : unlock_wr
	task automatic do_reset(input fuse_cfg_type f);
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		fuse <= f;
		tick(3);
		sys_rst <= 1'b0;
		tick(2);
	endtask : do_reset
	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	initial begin
		do_reset('{1'b1, mode_sampled, mode_continuous, 3'h7});
		rd_check(4'h0, 8'h19);
		rd_check(4'h1, 8'h07);
		for (int a = 2; a < 12; a++) rd_check(a[3:0], 8'h00);
		check({7'h00, rate}, 8'h01);
		wr(4'h0, 8'h00);
		rd_check(4'h0, 8'h19);
		wr(4'hd, 8'h00);
		tick(2);
		e0 = event_irq;
		wr(4'hd, 8'h03);
		tick(2);
		check({7'h00, e0 ^ event_irq}, 8'h01);
		rd_check(4'hc, 8'h02);
		tick(2);
		check({7'h00, event_irq}, 8'h00);
		unlock_wr(8'hf2, 0);
		rd_check(4'h0, 8'h1a);
		unlock_wr(8'h03, 0);
		rd_check(4'h0, 8'h1a);
		unlock_wr(8'h01, 4);
		rd_check(4'h0, 8'h1a);
		unlock_wr(8'h01, 1);
		rd_check(4'h0, 8'h19);
		@(posedge ref_clk);
		deep_sleep <= 1'b1;
		tick(4);
		rd_check(4'h0, 8'h19);
		check({6'h00, active_mode}, 8'h01);
		@(posedge ref_clk);
		deep_sleep <= 1'b0;
		tick(4);
		rd_check(4'h0, 8'h19);
		check({6'h00, active_mode}, 8'h02);
		wr(4'h8, 8'h02);
		rd_check(4'h8, 8'h02);
		check({6'h00, margin}, 8'h02);
		wr(4'h9, 8'h05);
		rd_check(4'h9, 8'h05);
		check({7'h00, mon_on}, 8'h01);
		@(posedge ref_clk);
		below <= 1'b1;
		tick(6);
		rd_check(4'hb, 8'h01);
		rd_check(4'ha, 8'h01);
		check({7'h00, warn_irq}, 8'h01);
		wr(4'ha, 8'h00);
		rd_check(4'ha, 8'h01);
		wr(4'ha, 8'h01);
		rd_check(4'ha, 8'h00);
		tick(1);
		check({7'h00, warn_irq}, 8'h00);
		// Each step flips the supply level under one direction setting
		for (int i = 0; i < 5; i++) begin
			wr(4'h9, {5'h00, dirs[i][1:0], 1'b1});
			@(posedge ref_clk);
			below <= lvls[i];
			tick(6);
			rd_check(4'ha, {7'h00, exps[i]});
			wr(4'ha, 8'h01);
		end
		wr(4'h9, 8'h04);
		@(posedge ref_clk);
		below <= 1'b1;
		tick(6);
		rd_check(4'ha, 8'h01);
		check({7'h00, warn_irq}, 8'h00);
		wr(4'h9, 8'h05);
		tick(2);
		check({7'h00, warn_irq}, 8'h01);
		wr(4'h9, 8'h04);
		tick(2);
		check({7'h00, warn_irq}, 8'h00);
		do_reset('{1'b0, mode_disabled, mode_disabled, 3'h2});
		rd_check(4'h0, 8'h00);
		rd_check(4'h1, 8'h02);
		rd_check(4'h9, 8'h00);
		wr(4'h9, 8'h05);
		@(posedge ref_clk);
		below <= 1'b0;
		tick(6);
		rd_check(4'ha, 8'h00);
		check({7'h00, mon_on}, 8'h00);
		complete_run();
	end

	initial begin
		tick(4000);
		n_errors++;
		complete_run();
	end
endmodule : supply_monitor_regs_bench
